// [verilog/pllctl_defs.svh]
// Constants for the loop control and configuration port block
`ifndef PLLCTL_DEFS_SVH
`define PLLCTL_DEFS_SVH
`define PLLCTL_ADDR_W 5
`define PLLCTL_DATA_W 8
`define PLLCTL_NUM_REGS 32
`define PLLCTL_REG_RESET 8'h00
// Address whose bit 0 selects the phase control source (1 = bus)
`define PLLCTL_PHASE_SRC_ADDR 5'h00
`define PLLCTL_PHASE_SRC_BIT 0
// Address whose bits 2:0 enable the secondary gate ports a, b, c
`define PLLCTL_PORT_EN_ADDR 5'h01
`define PLLCTL_PORT_EN_RESET 8'h07
// Core cycles for the loop to reacquire lock after a reset
`define PLLCTL_LOCK_CYCLES 16
`endif

// [verilog/pllctl_pkg.sv]
// Types for the loop control and configuration port block
package pllctl_pkg;
    typedef enum logic [1:0] {
        PLLCTL_RUN,
        PLLCTL_DRAIN,
        PLLCTL_DOWN
    } pllctl_pwr_type;
endpackage

// [verilog/pllctl_top.sv]
// Digital control of a phase-locked loop with its configuration bus
//
// Contract
// - primary output clock runs only while its gate input is high.
// - each secondary clock gated by its input when its port enable is set.
// - loop reset clears the loop but keeps the input divider state.
// - full reset clears the loop including the input divider.
// - divider b clear resets only the third output divider.
// - divider c clear resets only the fourth output divider.
// - lock goes high when locked; it is asynchronous, consumer synchronises.
// - standby input powers the loop down.
// - bus reset clears only bus logic, never stored configuration values.
// - data is eight bits each way, write data in, read data out.
// - device acknowledges each strobed access.
// - device flags whether phase control comes from ports or bus.
// - before power down every output clock is first driven low.
`timescale 1ns/1ps
`include "pllctl_defs.svh"
module pllctl_top #(
    parameter int ADDR_W = `PLLCTL_ADDR_W,
    parameter int DATA_W = `PLLCTL_DATA_W,
    parameter int LOCK_CYCLES = `PLLCTL_LOCK_CYCLES
) (
    input wire logic i_core_clk, // Core clock, 40 MHz
    input wire logic i_reset_n, // Synchronous reset, active low
    input wire logic i_ref_clk, // Loop reference (divided by input divider)
    input wire logic i_primary_out_gate, // Primary output enable
    input wire logic i_secondary_a_out_gate, // Secondary a enable
    input wire logic i_secondary_b_out_gate, // Secondary b enable
    input wire logic i_secondary_c_out_gate, // Secondary c enable
    input wire logic i_loop_reset, // Loop reset, input divider kept
    input wire logic i_loop_reset_full, // Loop reset incl. input divider
    input wire logic i_divider_b_clear, // Third output divider clear
    input wire logic i_divider_c_clear, // Fourth output divider clear
    input wire logic i_standby, // Power down request
    input wire logic i_cfg_bus_clock, // Configuration bus clock
    input wire logic i_cfg_bus_reset, // Bus logic reset, active high
    input wire logic i_cfg_bus_strobe, // Access strobe
    input wire logic i_cfg_bus_write_enable, // Write marker
    input wire logic [ADDR_W-1:0] i_cfg_bus_address, // Register address
    input wire logic [DATA_W-1:0] i_cfg_bus_write_data, // Write data
    output logic [DATA_W-1:0] o_cfg_bus_read_data, // Read data
    output logic o_cfg_bus_acknowledge, // Access done, one cycle
    output logic o_primary_out_clock, // Primary output clock
    output logic o_secondary_out_clock_a, // Secondary clock a
    output logic o_secondary_out_clock_b, // Secondary clock b
    output logic o_secondary_out_clock_c, // Secondary clock c
    output logic o_lock, // Loop locked
    output logic o_powered_down, // Loop is in standby
    output logic o_phase_control_source_flag, // 1: bus controls phase
    output logic [3:0] o_input_divider_count // Input divider state
);

    // ************************************************************
    // Configuration bus, on the bus clock
    // ************************************************************
    logic [DATA_W-1:0] cfg_mem_q [`PLLCTL_NUM_REGS];
    logic ack_q;
    logic [DATA_W-1:0] rdata_q;

    // Store resets only on core reset seen in bus domain through a sync
    logic core_rst_meta_q, core_rst_sync_q;
    always_ff @(posedge i_cfg_bus_clock) begin
        core_rst_meta_q <= ~i_reset_n;
        core_rst_sync_q <= core_rst_meta_q;
    end

    // Stored values survive the bus reset; only core reset defaults them
    always_ff @(posedge i_cfg_bus_clock) begin
        if (core_rst_sync_q) begin
            for (int i = 0; i < `PLLCTL_NUM_REGS; i++) begin
                cfg_mem_q[i] <= `PLLCTL_REG_RESET;
            end
            cfg_mem_q[`PLLCTL_PORT_EN_ADDR] <= `PLLCTL_PORT_EN_RESET;
        end else begin
            // Writes land at the strobe edge; the ack cycle blocks a repeat
            if (i_cfg_bus_strobe && i_cfg_bus_write_enable && !ack_q && !i_cfg_bus_reset) begin
                cfg_mem_q[i_cfg_bus_address] <= i_cfg_bus_write_data;
            end
        end
    end

    // Acknowledge is a single pulse; while the strobe is still held it pulses again every second cycle
    always_ff @(posedge i_cfg_bus_clock) begin
        if (i_cfg_bus_reset) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= i_cfg_bus_strobe && !ack_q;
            if (i_cfg_bus_strobe && !ack_q) begin
                rdata_q <= cfg_mem_q[i_cfg_bus_address];
            end
        end
    end
    assign o_cfg_bus_acknowledge = ack_q;
    assign o_cfg_bus_read_data = rdata_q;

    // ************************************************************
    // Crossing of static configuration bits into the core domain
    // ************************************************************
    // Levels only; a change settles within two core cycles
    // The bits are independent port enables and the phase source flag, so a cycle of skew between them is harmless
    logic [3:0] cfg_meta_q, cfg_sync_q;
    logic [3:0] cfg_bits;
    assign cfg_bits = {cfg_mem_q[`PLLCTL_PORT_EN_ADDR][2:0],
                       cfg_mem_q[`PLLCTL_PHASE_SRC_ADDR][`PLLCTL_PHASE_SRC_BIT]};
    always_ff @(posedge i_core_clk) begin
        cfg_meta_q <= cfg_bits;
        cfg_sync_q <= cfg_meta_q;
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_raw, pin_meta_q, pin_q;
    assign pin_raw = {i_ref_clk, i_primary_out_gate, i_secondary_a_out_gate,
                      i_secondary_b_out_gate, i_secondary_c_out_gate, i_loop_reset,
                      i_loop_reset_full, i_divider_b_clear, i_divider_c_clear, i_standby};
    always_ff @(posedge i_core_clk) begin
        pin_meta_q <= pin_raw;
        pin_q <= pin_meta_q;
    end
    logic ref_s, gate_p, gate_a, gate_b, gate_c, rst_s, rstf_s, clrb_s, clrc_s, stby_s;
    assign {ref_s, gate_p, gate_a, gate_b, gate_c, rst_s, rstf_s, clrb_s, clrc_s, stby_s} = pin_q;

    // ************************************************************
    // Loop model: input divider, lock counter, output dividers
    // ************************************************************
    logic ref_d1_q;
    logic [3:0] in_div_q;
    logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_q;
    logic [3:0] vco_q;
    logic [1:0] div_b_q, div_c_q;
    logic loop_rst;
    pllctl_pkg::pllctl_pwr_type pwr_q;
    logic out_en;

    // ************************************************************
    // State decode
    // ************************************************************
    // Power state decode shared by the loop reset and the status output
    function automatic logic pwr_is_down(input pllctl_pkg::pllctl_pwr_type s);
        return s == pllctl_pkg::PLLCTL_DOWN;
    endfunction
    assign loop_rst = rst_s || rstf_s || pwr_is_down(pwr_q);

    // Input divider counts reference edges; only core reset and the full reset clear it
    always_ff @(posedge i_core_clk) begin
        ref_d1_q <= ref_s;
        if (!i_reset_n || rstf_s) begin
            in_div_q <= 4'h0;
        end else if (ref_s && !ref_d1_q) begin
            in_div_q <= in_div_q + 4'h1;
        end
    end
    assign o_input_divider_count = in_div_q;

    // Lock counter restarts on any loop reset
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || loop_rst) begin
            lock_cnt_q <= '0;
        end else if (lock_cnt_q != LOCK_CYCLES[$bits(lock_cnt_q)-1:0]) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
        end
    end
    assign o_lock = (lock_cnt_q == LOCK_CYCLES[$bits(lock_cnt_q)-1:0]);

    // Free oscillator and per-output dividers
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || loop_rst) begin
            vco_q <= 4'h0;
        end else begin
            vco_q <= vco_q + 4'h1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || loop_rst || clrb_s) begin
            div_b_q <= 2'h0;
        end else begin
            div_b_q <= div_b_q + 2'h1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || loop_rst || clrc_s) begin
            div_c_q <= 2'h0;
        end else begin
            div_c_q <= div_c_q + 2'h1;
        end
    end

    // ************************************************************
    // Standby sequencing: drain outputs low, then power down
    // ************************************************************
    logic all_low;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            pwr_q <= pllctl_pkg::PLLCTL_RUN;
        end else begin
            unique case (pwr_q)
                pllctl_pkg::PLLCTL_RUN: if (stby_s) pwr_q <= pllctl_pkg::PLLCTL_DRAIN;
                pllctl_pkg::PLLCTL_DRAIN: begin
                    if (!stby_s) pwr_q <= pllctl_pkg::PLLCTL_RUN;
                    else if (all_low) pwr_q <= pllctl_pkg::PLLCTL_DOWN;
                end
                pllctl_pkg::PLLCTL_DOWN: if (!stby_s) pwr_q <= pllctl_pkg::PLLCTL_RUN;
            endcase
        end
    end
    assign out_en = (pwr_q == pllctl_pkg::PLLCTL_RUN) && o_lock;
    assign o_powered_down = pwr_is_down(pwr_q);

    // A cleared port enable makes the gate pin a don't-care
    logic sec_a_en, sec_b_en, sec_c_en;
    assign sec_a_en = gate_a || !cfg_sync_q[1];
    assign sec_b_en = gate_b || !cfg_sync_q[2];
    assign sec_c_en = gate_c || !cfg_sync_q[3];

    // Gated outputs registered; drain stops enabling so each falls low
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_primary_out_clock <= 1'b0;
            o_secondary_out_clock_a <= 1'b0;
            o_secondary_out_clock_b <= 1'b0;
            o_secondary_out_clock_c <= 1'b0;
        end else begin
            o_primary_out_clock <= out_en && gate_p && vco_q[0];
            o_secondary_out_clock_a <= out_en && sec_a_en && vco_q[1];
            o_secondary_out_clock_b <= out_en && sec_b_en && div_b_q[1];
            o_secondary_out_clock_c <= out_en && sec_c_en && div_c_q[1];
        end
    end
    assign all_low = !(o_primary_out_clock || o_secondary_out_clock_a ||
                       o_secondary_out_clock_b || o_secondary_out_clock_c);
    assign o_phase_control_source_flag = cfg_sync_q[0];

    // ************************************************************
    // Assertions
    // ************************************************************
    primary_gated_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !$past(gate_p) |-> !o_primary_out_clock) else $error("primary clock ran while gated");
    sec_a_gated_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ($past(cfg_sync_q[1]) && !$past(gate_a)) |-> !o_secondary_out_clock_a)
        else $error("secondary a ran while gated");
    keep_divider_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (rst_s && !rstf_s && ref_s && !ref_d1_q) |=> in_div_q == $past(in_div_q) + 4'h1)
        else $error("loop reset disturbed input divider");
    full_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        rstf_s |=> (in_div_q == 4'h0) && !o_lock) else $error("full reset left state");
    div_b_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (clrb_s && !clrc_s && !loop_rst) |=> div_b_q == 2'h0
        && vco_q == $past(vco_q) + 4'h1 && div_c_q == $past(div_c_q) + 2'h1)
        else $error("divider b clear wrong scope");
    div_c_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (clrc_s && !clrb_s && !loop_rst) |=> div_c_q == 2'h0
        && div_b_q == $past(div_b_q) + 2'h1)
        else $error("divider c clear wrong scope");
    lock_time_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(loop_rst) |-> !o_lock [*8]) else $error("lock came too early");
    standby_down_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        stby_s [*8] |=> o_powered_down) else $error("standby did not power down");
    drain_low_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(o_powered_down) |-> $past(all_low)) else $error("powered down with clock high");
    ack_pulse_a: assert property (@(posedge i_cfg_bus_clock)
        disable iff (i_cfg_bus_reset)
        o_cfg_bus_acknowledge |=> !o_cfg_bus_acknowledge)
        else $error("ack longer than one cycle");
    ack_follows_a: assert property (@(posedge i_cfg_bus_clock)
        disable iff (i_cfg_bus_reset)
        (i_cfg_bus_strobe && !o_cfg_bus_acknowledge) |=> o_cfg_bus_acknowledge)
        else $error("strobe not acknowledged");
    bus_rst_keep_a: assert property (@(posedge i_cfg_bus_clock)
        disable iff (core_rst_sync_q)
        i_cfg_bus_reset |=> cfg_mem_q[0] == $past(cfg_mem_q[0]))
        else $error("bus reset lost value");

    // Further gate, divider and standby checks in the core domain
    sec_b_gated_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ($past(cfg_sync_q[2]) && !$past(gate_b)) |-> !o_secondary_out_clock_b)
        else $error("secondary b ran while gated");
    sec_c_gated_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ($past(cfg_sync_q[3]) && !$past(gate_c)) |-> !o_secondary_out_clock_c)
        else $error("secondary c ran while gated");
    divider_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (!rstf_s && !(ref_s && !ref_d1_q)) |=> $stable(in_div_q))
        else $error("input divider moved without an edge");
    down_unlock_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_powered_down |=> !o_lock) else $error("lock held while powered down");
    down_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_powered_down |-> all_low) else $error("clock high while powered down");
    wake_up_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (o_powered_down && !stby_s) |=> !o_powered_down) else $error("stayed down after wake");
    // Bus reset silences the acknowledge but leaves the store alone
    bus_rst_quiet_a: assert property (@(posedge i_cfg_bus_clock)
        disable iff (core_rst_sync_q)
        i_cfg_bus_reset |=> !o_cfg_bus_acknowledge) else $error("acknowledge during bus reset");

    // Covers for the main scenarios
    cov_lock_c: cover property (@(posedge i_core_clk) $rose(o_lock));
    cov_down_c: cover property (@(posedge i_core_clk) $rose(o_powered_down));
    cov_write_c: cover property (@(posedge i_cfg_bus_clock)
        i_cfg_bus_strobe && i_cfg_bus_write_enable ##1 o_cfg_bus_acknowledge);
    cov_clrb_c: cover property (@(posedge i_core_clk) clrb_s && o_lock);
    cov_busrst_c: cover property (@(posedge i_cfg_bus_clock) $fell(i_cfg_bus_reset));

endmodule

// [sim/pllctl_host.sv]
// Fabric-side partner model: configuration bus master and lock synchroniser
`timescale 1ns/1ps
module pllctl_host (
    input wire logic i_clk, // Bus clock
    input wire logic i_ack, // Device acknowledge
    input wire logic [7:0] i_rdata, // Device read data
    input wire logic i_lock, // Raw lock, asynchronous
    output logic o_stb, // Access strobe
    output logic o_we, // Write mark
    output logic [4:0] o_addr, // Register address
    output logic [7:0] o_wdata, // Write data
    output logic o_lock_s // Lock in bus domain
);
    logic [1:0] sync_q;
    // Idle bus at time zero
    initial begin
        o_stb = 1'b0;
        o_we = 1'b0;
        o_addr = 5'h1F;
        o_wdata = 8'hA5;
    end
    // Two flops tame the asynchronous lock before any use of it
    always_ff @(posedge i_clk) sync_q <= {sync_q[0], i_lock};
    assign o_lock_s = sync_q[1];
    // One access; everything held until acknowledge is seen at an edge or 8 edges pass
    task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        @(posedge i_clk);
        #1;
        o_stb = 1'b1;
        o_we = we;
        o_addr = a;
        o_wdata = d;
        q = 8'hXX;
        n = 0;
        while (n < 8) begin
            @(posedge i_clk);
            n++;
            if (i_ack === 1'b1) begin
                q = i_rdata;
                n = 99;
            end
        end
        #1;
        o_stb = 1'b0;
        o_we = 1'b0;
        // Released lines show the inverse so a stale value cannot pass
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule

// [sim/pllctl_top_tb.sv]
// Self-checking testbench for the loop control block
`timescale 1ns/1ps
module pllctl_top_tb;
    logic clk = 1'b0, bclk = 1'b0, rst_n = 1'b0, ref_clk = 1'b0, ref_run = 1'b1;
    logic pg = 1'b1, ag = 1'b1, bg = 1'b1, cg = 1'b1, lr = 1'b0, lrf = 1'b0;
    logic dbc = 1'b0, dcc = 1'b0, stby = 1'b0, brst = 1'b0;
    logic stb, we, ack, lock, pdn, psf, lock_s;
    logic [4:0] addr;
    logic [7:0] wdat, rdat, q;
    logic [3:0] divc, h;
    wire [3:0] clks;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    int mdl[32];
    // Clocks of unrelated rates; the timeout guards against a hang
    always #12.5 clk = ~clk;
    always #15 bclk = ~bclk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    // Reference edges at random spacing while allowed to run
    always @(posedge clk) if (ref_run) ref_clk <= #1 ($urandom % 2) ? ~ref_clk : ref_clk;
    pllctl_top i_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_ref_clk(ref_clk),
        .i_primary_out_gate(pg), .i_secondary_a_out_gate(ag), .i_secondary_b_out_gate(bg),
        .i_secondary_c_out_gate(cg), .i_loop_reset(lr), .i_loop_reset_full(lrf),
        .i_divider_b_clear(dbc), .i_divider_c_clear(dcc), .i_standby(stby),
        .i_cfg_bus_clock(bclk), .i_cfg_bus_reset(brst), .i_cfg_bus_strobe(stb),
        .i_cfg_bus_write_enable(we), .i_cfg_bus_address(addr), .i_cfg_bus_write_data(wdat),
        .o_cfg_bus_read_data(rdat), .o_cfg_bus_acknowledge(ack),
        .o_primary_out_clock(clks[0]), .o_secondary_out_clock_a(clks[1]),
        .o_secondary_out_clock_b(clks[2]), .o_secondary_out_clock_c(clks[3]),
        .o_lock(lock), .o_powered_down(pdn), .o_phase_control_source_flag(psf),
        .o_input_divider_count(divc));
    pllctl_host i_host (.i_clk(bclk), .i_ack(ack), .i_rdata(rdat), .i_lock(lock),
        .o_stb(stb), .o_we(we), .o_addr(addr), .o_wdata(wdat), .o_lock_s(lock_s));
    // ********************************
    // Shared tasks
    // ********************************
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Which output clocks were seen high over n cycles
    task obs(input int n, output logic [3:0] hi);
        hi = 4'h0;
        repeat (n) begin
            @(posedge clk);
            hi = hi | clks;
        end
        #1;
    endtask
    task wlock(output int n);
        n = 0;
        while (lock !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask
    task wr(input int a, input logic [7:0] d);
        i_host.xfer(1'b1, 5'(a), d, q);
        mdl[a] = d;
        chk(!$isunknown(q), "write not acknowledged");
    endtask
    task rd(input int a);
        i_host.xfer(1'b0, 5'(a), 8'h00, q);
        chk(q === 8'(mdl[a]), "read data differs from model");
    endtask
    task test_done();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        int n;
        logic [3:0] cnt;
        void'($urandom(17));
        foreach (mdl[i]) mdl[i] = 0;
        mdl[1] = 8'h07;
        tick(10);
        rst_n = 1'b1;
        repeat (4) @(posedge bclk);
        for (int i = 0; i < 32; i++) rd(i);
        // Random back-to-back traffic over all addresses
        repeat (40) begin
            n = $urandom % 32;
            wr(n, 8'($urandom));
            rd(n);
        end
        for (int v = 0; v < 2; v++) begin
            wr(0, 8'(v));
            tick(6);
            chk(psf === v[0], "phase source flag");
        end
        wr(9, 8'($urandom));
        @(posedge bclk) #1 brst = 1'b1;
        repeat (3) @(posedge bclk);
        #1 brst = 1'b0;
        rd(9);
        wr(1, 8'h07);
        wlock(n);
        // Loop reset keeps the input divider, full reset clears it
        ref_run = 1'b0;
        tick(8);
        cnt = divc;
        lr = 1'b1;
        tick(6);
        chk(lock === 1'b0 && divc === cnt, "loop reset");
        ref_run = 1'b1;
        tick(12);
        chk(lock === 1'b0, "lock held in loop reset");
        lr = 1'b0;
        wlock(n);
        chk(n >= 16 && n <= 24, "lock delay");
        lrf = 1'b1;
        tick(6);
        chk(lock === 1'b0 && divc === 4'h0, "full reset");
        lrf = 1'b0;
        wlock(n);
        pg = 1'b0;
        tick(4);
        obs(16, h);
        chk(h[0] === 1'b0 && h[1] === 1'b1, "primary gate low");
        pg = 1'b1;
        tick(4);
        obs(16, h);
        chk(h[0] === 1'b1, "primary gate high");
        // Secondary gates bite only while their port enable is set
        for (int k = 0; k < 3; k++) begin
            {cg, bg, ag} = ~(3'h1 << k);
            tick(4);
            obs(16, h);
            chk(h[k + 1] === 1'b0, "secondary gated");
            wr(1, 8'h07 ^ (8'h01 << k));
            tick(6);
            obs(16, h);
            chk(h[k + 1] === 1'b1, "port disabled gate ignored");
            wr(1, 8'h07);
            {cg, bg, ag} = 3'h7;
        end
        for (int k = 0; k < 2; k++) begin
            {dcc, dbc} = 2'h1 << k;
            tick(4);
            obs(16, h);
            chk(h[k + 2] === 1'b0 && h[3 - k] === 1'b1, "clear scope");
            chk(h[1] === 1'b1 && lock === 1'b1, "clear kept loop");
            {dcc, dbc} = 2'h0;
            tick(4);
        end
        // Standby: outputs drained low before power down
        stby = 1'b1;
        n = 0;
        while (pdn !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk(pdn === 1'b1 && clks === 4'h0, "standby power down");
        tick(3);
        chk(lock === 1'b0, "lock after standby");
        stby = 1'b0;
        wlock(n);
        chk(lock === 1'b1, "relock after standby");
        repeat (3) @(posedge bclk);
        #1;
        chk(lock_s === 1'b1, "synchronised lock");
        test_done();
    end
endmodule
